// File: design/mbf_device.sv
// Device end: frame receiver, register store, acknowledge and output filter.
// Assumes the link strobes come from logic on the same clock.
// Notes on behaviour
// - Frames bounded by 3.5 character silences
// - Master sends address, 0x10, start, count, bytes, data
// - Good write answered with echo and CRC
// - Out of range value leaves register unchanged
// - Master should read back written registers; the master end here sends write frames only, no read-back
// - Wire address is register number minus one
// - Floats span two registers, low word first
// - Filter factor lives at register 777
// - New measurement about every two seconds
// - Factor resets to 1.0, no filtering
// - Factor register 0 to 100, over 100
// - Output moves by factor times the difference
//
// The implementer's own choice: the AHB-Lite slave port.
`default_nettype none
module mbf_device
	import mbf_pkg::*;
#(
	parameter int unsigned CHAR_CYCLES = CHAR_CYC_DEF,  // Character time
	parameter int unsigned MEAS_CYCLES = MEAS_CYC_DEF,  // Measurement period
	parameter logic [7:0]  DEV_ADDR    = DEV_ADDR_DEF,  // Slave address
	parameter int unsigned MEAS_W      = 16,            // Measurement width
	parameter int unsigned FRAC_W      = 16             // Filter fraction
) (
	// Clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// Link
	mbf_link_if.device             link,
	// Measurement side
	input  wire logic [MEAS_W-1:0] meas_value,
	output var  logic              sample_take,
	output var  logic [MEAS_W-1:0] filt_out,
	// Register contents
	output var  logic [31:0]       comp_pressure,
	output var  logic [15:0]       filter_factor,
	output var  logic              frame_ok,
	output var  logic              frame_bad
);
	localparam int unsigned SILENCE =
		(CHAR_CYCLES * SIL_NUM + SIL_DEN - 1) / SIL_DEN;
	localparam logic [31:0] SIL_W  = 32'(SILENCE);
	localparam logic [31:0] CHAR_W = 32'(CHAR_CYCLES);
	localparam logic [31:0] MEAS_W32 = 32'(MEAS_CYCLES);
	localparam int unsigned AW = MEAS_W + FRAC_W + 2;    // Accumulator
	localparam int unsigned PW = AW + 18;                // Product
	localparam logic signed [PW-1:0] FAC_DIV = PW'(FACTOR_SCALE);
	localparam logic signed [AW-1:0] HALF = AW'(1) <<< (FRAC_W - 1);

	// Whole state of the device end
	typedef struct packed {
		logic [31:0]           rx_gap;     // Cycles since last character
		logic [7:0]            rx_cnt;     // Characters in this frame
		logic [15:0]           rx_crc;     // Running CRC
		logic                  rx_bad;     // Not ours or malformed
		logic [15:0]           start_addr; // Echoed start address
		logic [15:0]           reg_count;  // Echoed register count
		logic [7:0]            byte_count; // Declared data bytes
		logic [7:0]            word_hi;    // First byte of a word
		logic [15:0]           sh_lo;      // Staged pressure low word
		logic [15:0]           sh_hi;      // Staged pressure high word
		logic [15:0]           sh_fac;     // Staged filter factor
		logic [2:0]            sh_wr;      // Staged word present
		logic [31:0]           press;      // Compensation pressure
		logic [15:0]           factor;     // Filter factor, hundredths
		mbf_tx_type            tx_state;   // Reply sender state
		logic [3:0]            tx_idx;     // Reply byte index
		logic [31:0]           tx_timer;   // Character spacing
		logic [15:0]           tx_crc;     // Reply CRC
		logic                  tx_valid;   // Character strobe
		logic [7:0]            tx_data;    // Character
		logic [31:0]           meas_timer; // Measurement period
		logic signed [AW-1:0]  acc;        // Filter accumulator
		logic                  filt_init;  // Accumulator loaded
		logic [MEAS_W-1:0]     filt_out;   // Rounded output
		logic                  take;       // Sample pulse
		logic                  ok;         // Accepted frame pulse
		logic                  bad;        // Rejected frame pulse
	} mbfd_state_type;

	mbfd_state_type        st;     // Registered state
	mbfd_state_type        nx;     // Next state
	logic [7:0]            rx_b;   // Received character
	logic [7:0]            dk;     // Data byte index
	logic [15:0]           word;   // Completed data word
	logic [15:0]           ra;     // Register address of the word
	logic                  good;   // Frame passes all checks
	logic [7:0]            tb;     // Reply character
	logic signed [AW-1:0]  mfix;   // Measurement in fixed point
	logic signed [AW:0]    diff;   // Measurement minus output
	logic signed [PW-1:0]  prod;   // Difference times factor
	logic signed [PW-1:0]  step;   // Scaled step
	logic signed [AW-1:0]  acc_n;  // New accumulator

	// Next state of receiver, sender and filter
	always_comb begin
		nx    = st;
		rx_b  = link.m2s_data;
		dk    = st.rx_cnt - RQ_DATA;
		word  = {st.word_hi, link.m2s_data};
		ra    = st.start_addr + {9'h000, dk[7:1]};
		good  = 1'b0;
		tb    = 8'h00;
		mfix  = AW'({2'b00, meas_value}) <<< FRAC_W;
		diff  = {mfix[AW-1], mfix} - {st.acc[AW-1], st.acc};
		prod  = PW'(diff) * PW'($signed({1'b0, st.factor}));
		step  = prod / FAC_DIV;
		acc_n = st.acc + AW'(step);
		nx.tx_valid = 1'b0;
		nx.take     = 1'b0;
		nx.ok       = 1'b0;
		nx.bad      = 1'b0;
		// Silence counter saturates at the frame gap
		if (st.rx_gap < SIL_W) begin
			nx.rx_gap = st.rx_gap + 32'h0000_0001;
		end
		if (link.m2s_valid) begin
			// Character of the current request
			nx.rx_gap = 32'h0000_0000;
			nx.rx_crc = mbf_crc_step((st.rx_cnt == 8'h00) ? CRC_INIT
				: st.rx_crc, rx_b);
			if (st.rx_cnt != 8'hFF) begin
				nx.rx_cnt = st.rx_cnt + 8'h01;
			end
			if (st.rx_cnt == {4'h0, IX_ADDR}) begin
				nx.rx_bad = (rx_b != DEV_ADDR);
				nx.sh_wr  = 3'b000;
			end else if (st.rx_cnt == {4'h0, IX_FUNC}) begin
				nx.rx_bad = st.rx_bad | (rx_b != FUNC_WR_MULTI);
			end else if (st.rx_cnt == {4'h0, IX_START_HI}) begin
				nx.start_addr[15:8] = rx_b;
			end else if (st.rx_cnt == {4'h0, IX_START_LO}) begin
				nx.start_addr[7:0] = rx_b;
			end else if (st.rx_cnt == {4'h0, IX_COUNT_HI}) begin
				nx.reg_count[15:8] = rx_b;
			end else if (st.rx_cnt == {4'h0, IX_COUNT_LO}) begin
				nx.reg_count[7:0] = rx_b;
			end else if (st.rx_cnt == {4'h0, IX_BYTES}) begin
				nx.byte_count = rx_b;
			end else if (dk < st.byte_count) begin
				// Data bytes pair high then low into one register
				if (!dk[0]) begin
					nx.word_hi = rx_b;
				end else if (ra == REG_PRESS_LO) begin
					nx.sh_lo    = word;
					nx.sh_wr[0] = 1'b1;
				end else if (ra == REG_PRESS_HI) begin
					nx.sh_hi    = word;
					nx.sh_wr[1] = 1'b1;
				end else if (ra == REG_FACTOR) begin
					nx.sh_fac   = word;
					nx.sh_wr[2] = 1'b1;
				end
			end
		end else if (st.rx_cnt != 8'h00 && st.rx_gap == SIL_W) begin
			// Frame closed by silence: check and commit
			nx.rx_cnt = 8'h00;
			good = !st.rx_bad && st.rx_crc == 16'h0000
				&& {8'h00, st.rx_cnt} == {8'h00, RQ_DATA}
				+ {8'h00, st.byte_count} + {8'h00, CRC_LEN}
				&& {8'h00, st.byte_count} == {st.reg_count[14:0], 1'b0}
				&& st.tx_state == TX_IDLE;
			nx.ok  = good;
			nx.bad = !good;
			if (good) begin
				if (st.sh_wr[0]) begin
					nx.press[15:0] = st.sh_lo;
				end
				if (st.sh_wr[1]) begin
					nx.press[31:16] = st.sh_hi;
				end
				if (st.sh_wr[2] && st.sh_fac <= FACTOR_MAX) begin
					nx.factor = st.sh_fac;
				end
				nx.tx_state = TX_SEND;
				nx.tx_idx   = 4'h0;
				nx.tx_timer = 32'h0000_0000;
				nx.tx_crc   = CRC_INIT;
			end
		end
		// Reply sender, one character per character time
		if (st.tx_state == TX_SEND) begin
			if (st.tx_timer != 32'h0000_0000) begin
				nx.tx_timer = st.tx_timer - 32'h0000_0001;
			end else begin
				if (st.tx_idx == IX_RESP_CRC) begin
					tb = st.tx_crc[7:0];
				end else if (st.tx_idx == IX_RESP_LAST) begin
					tb = st.tx_crc[15:8];
				end else begin
					tb = mbf_hdr_byte(st.tx_idx, DEV_ADDR, st.start_addr,
						st.reg_count);
				end
				if (st.tx_idx < IX_RESP_CRC) begin
					nx.tx_crc = mbf_crc_step(st.tx_crc, tb);
				end
				nx.tx_valid = 1'b1;
				nx.tx_data  = tb;
				nx.tx_timer = CHAR_W - 32'h0000_0001;
				nx.tx_idx   = st.tx_idx + 4'h1;
				if (st.tx_idx == IX_RESP_LAST) begin
					nx.tx_state = TX_IDLE;
				end
			end
		end
		// Measurement period and recursive filter
		if (st.meas_timer == MEAS_W32 - 32'h0000_0001) begin
			nx.meas_timer = 32'h0000_0000;
			nx.take       = 1'b1;
			nx.filt_init  = 1'b1;
			if (!st.filt_init) begin
				acc_n = mfix;
			end
			nx.acc      = acc_n;
			nx.filt_out = MEAS_W'((acc_n + HALF) >>> FRAC_W);
		end else begin
			nx.meas_timer = st.meas_timer + 32'h0000_0001;
		end
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st        <= '0;
			st.factor <= FACTOR_RESET;
		end else begin
			st <= nx;
		end
	end

	// Outputs straight from the state register
	assign link.s2m_valid = st.tx_valid;
	assign link.s2m_data  = st.tx_data;
	assign sample_take    = st.take;
	assign filt_out       = st.filt_out;
	assign comp_pressure  = st.press;
	assign filter_factor  = st.factor;
	assign frame_ok       = st.ok;
	assign frame_bad      = st.bad;
endmodule : mbf_device
`default_nettype wire

// File: design/mbf_link_if.sv
// Byte-level serial link between the master end and the device end.
// Each strobe carries one character; senders space them a character apart.
`default_nettype none
interface mbf_link_if;
	logic       m2s_valid; // Master character strobe
	logic [7:0] m2s_data;  // Master character
	logic       s2m_valid; // Device character strobe
	logic [7:0] s2m_data;  // Device character
	modport master (output m2s_valid, output m2s_data,
		input s2m_valid, input s2m_data);
	modport device (input m2s_valid, input m2s_data,
		output s2m_valid, output s2m_data);
endinterface : mbf_link_if
`default_nettype wire

// File: design/mbf_master.sv
// Master end: AHB-Lite register slave that sends one write frame per order.
// Assumes a single AHB-Lite master and link strobes on the same clock.
`default_nettype none
module mbf_master
	import mbf_pkg::*;
#(
	parameter int unsigned CHAR_CYCLES = CHAR_CYC_DEF,  // Character time
	parameter int unsigned TMO_CYCLES  = CHAR_CYC_DEF * RESP_TMO_CHARS
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic [31:0] hrdata,
	output var  logic        hreadyout,
	output var  logic        hresp,
	// Link
	mbf_link_if.master       link
);
	localparam int unsigned SILENCE =
		(CHAR_CYCLES * SIL_NUM + SIL_DEN - 1) / SIL_DEN;
	localparam logic [31:0] SIL_W  = 32'(SILENCE);
	localparam logic [31:0] CHAR_W = 32'(CHAR_CYCLES);
	localparam logic [31:0] TMO_W  = 32'(TMO_CYCLES);

	// Whole state of the master end
	typedef struct packed {
		logic        ap_valid; // Data phase pending
		logic        ap_write; // Pending phase is a write
		logic [7:0]  ap_addr;  // Pending offset
		logic [31:0] rdata;    // Read data
		logic        rdy;      // Ready out
		logic [7:0]  slave;    // Target address
		logic [15:0] start;    // Wire start address
		logic [1:0]  count;    // Registers to write
		logic [15:0] data0;    // First register value
		logic [15:0] data1;    // Second register value
		logic [3:0]  status;   // Busy, done, ack ok, ack bad
		mbf_mst_type fsm;      // Sequencer state
		logic [31:0] gap;      // Cycles since any character
		logic [3:0]  idx;      // Byte index
		logic [31:0] timer;    // Spacing or timeout
		logic [15:0] crc;      // Running CRC
		logic        rx_bad;   // Echo mismatch
		logic        tx_valid; // Character strobe
		logic [7:0]  tx_data;  // Character
	} mbfm_state_type;

	mbfm_state_type st;     // Registered state
	mbfm_state_type nx;     // Next state
	logic           go;     // Start order this cycle
	logic [3:0]     dend;   // Index of the first CRC byte
	logic [7:0]     tb;     // Request character
	logic [15:0]    cnt16;  // Count as sent
	logic           ok;     // Reply passes checks

	// Next state of bus slave and sequencer
	always_comb begin
		nx    = st;
		go    = 1'b0;
		cnt16 = {14'h0000, st.count};
		dend  = RQ_DATA[3:0] + {1'b0, st.count, 1'b0};
		tb    = 8'h00;
		ok    = 1'b0;
		nx.tx_valid = 1'b0;
		nx.rdy      = 1'b1;
		nx.ap_valid = hsel && htrans[1] && hready;
		nx.ap_write = hwrite;
		nx.ap_addr  = haddr[7:0];
		// Read data registered in the address phase
		if (haddr[7:0] == A_STATUS) begin
			nx.rdata = {28'h000_0000, st.status};
		end else if (haddr[7:0] == A_SLAVE) begin
			nx.rdata = {24'h00_0000, st.slave};
		end else if (haddr[7:0] == A_START) begin
			nx.rdata = {16'h0000, st.start};
		end else if (haddr[7:0] == A_COUNT) begin
			nx.rdata = {30'h0000_0000, st.count};
		end else if (haddr[7:0] == A_DATA0) begin
			nx.rdata = {16'h0000, st.data0};
		end else if (haddr[7:0] == A_DATA1) begin
			nx.rdata = {16'h0000, st.data1};
		end else begin
			nx.rdata = 32'h0000_0000;
		end
		// Writes land in the data phase
		if (st.ap_valid && st.ap_write) begin
			if (st.ap_addr == A_CTRL) begin
				go = hwdata[0] && !st.status[ST_BUSY]
					&& st.count != 2'b00 && st.count != 2'b11;
			end else if (st.ap_addr == A_STATUS) begin
				nx.status[3:1] = st.status[3:1] & ~hwdata[3:1];
			end else if (st.ap_addr == A_SLAVE) begin
				nx.slave = hwdata[7:0];
			end else if (st.ap_addr == A_START) begin
				nx.start = hwdata[15:0];
			end else if (st.ap_addr == A_COUNT) begin
				nx.count = hwdata[1:0];
			end else if (st.ap_addr == A_DATA0) begin
				nx.data0 = hwdata[15:0];
			end else if (st.ap_addr == A_DATA1) begin
				nx.data1 = hwdata[15:0];
			end
		end
		// Line silence seen from either direction
		if (st.tx_valid || link.s2m_valid) begin
			nx.gap = 32'h0000_0000;
		end else if (st.gap < SIL_W) begin
			nx.gap = st.gap + 32'h0000_0001;
		end
		// Sequencer
		case (st.fsm)
			M_IDLE: begin
				if (go) begin
					nx.status = 4'b0001;
					nx.fsm    = M_GAP;
				end
			end
			M_GAP: begin
				if (st.gap >= SIL_W) begin
					nx.fsm   = M_SEND;
					nx.idx   = 4'h0;
					nx.timer = 32'h0000_0000;
					nx.crc   = CRC_INIT;
				end
			end
			M_SEND: begin
				if (st.timer != 32'h0000_0000) begin
					nx.timer = st.timer - 32'h0000_0001;
				end else begin
					if (st.idx < IX_BYTES) begin
						tb = mbf_hdr_byte(st.idx, st.slave, st.start, cnt16);
					end else if (st.idx == IX_BYTES) begin
						tb = {5'h00, st.count, 1'b0};
					end else if (st.idx == dend) begin
						// CRC first, so a one-word frame never sends data1
						tb = st.crc[7:0];
					end else if (st.idx == dend + 4'h1) begin
						tb = st.crc[15:8];
					end else if (st.idx == 4'h7) begin
						tb = st.data0[15:8];
					end else if (st.idx == 4'h8) begin
						tb = st.data0[7:0];
					end else if (st.idx == 4'h9) begin
						tb = st.data1[15:8];
					end else begin
						tb = st.data1[7:0];
					end
					if (st.idx < dend) begin
						nx.crc = mbf_crc_step(st.crc, tb);
					end
					nx.tx_valid = 1'b1;
					nx.tx_data  = tb;
					nx.timer    = CHAR_W - 32'h0000_0001;
					nx.idx      = st.idx + 4'h1;
					if (st.idx == dend + 4'h1) begin
						nx.fsm    = M_RESP;
						nx.idx    = 4'h0;
						nx.timer  = 32'h0000_0000;
						nx.crc    = CRC_INIT;
						nx.rx_bad = 1'b0;
					end
				end
			end
			M_RESP: begin
				nx.timer = st.timer + 32'h0000_0001;
				if (link.s2m_valid) begin
					nx.crc = mbf_crc_step(st.crc, link.s2m_data);
					if (st.idx != 4'hF) begin
						nx.idx = st.idx + 4'h1;
					end
					if (st.idx < IX_RESP_CRC && link.s2m_data !=
						mbf_hdr_byte(st.idx, st.slave, st.start, cnt16)) begin
						nx.rx_bad = 1'b1;
					end
				end else if ((st.idx != 4'h0 && st.gap == SIL_W)
					|| (st.idx == 4'h0 && st.timer >= TMO_W)) begin
					ok = !st.rx_bad && st.idx == RESP_LEN
						&& st.crc == 16'h0000;
					nx.status[ST_BUSY]    = 1'b0;
					nx.status[ST_DONE]    = 1'b1;
					nx.status[ST_ACK_OK]  = ok;
					nx.status[ST_ACK_BAD] = !ok;
					nx.fsm = M_IDLE;
				end
			end
			default: nx.fsm = M_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st     <= '0;
			st.rdy <= 1'b1;
		end else begin
			st <= nx;
		end
	end

	// Outputs straight from the state register, except hresp, which is tied low
	assign hrdata         = st.rdata;
	assign hreadyout      = st.rdy;
	assign hresp          = 1'b0;
	assign link.m2s_valid = st.tx_valid;
	assign link.m2s_data  = st.tx_data;
endmodule : mbf_master
`default_nettype wire

// File: design/mbf_pkg.sv
// Constants, state encodings and the frame CRC shared by both link ends.
// Assumes one 25 MHz clock common to the device end and the master end.
`default_nettype none
package mbf_pkg;
	// Clock and character timing
	localparam int unsigned CLK_HZ        = 25_000_000; // System clock rate
	localparam int unsigned BAUD_DEFAULT  = 19_200;     // Line rate, bit/s
	localparam int unsigned CHAR_BITS     = 11;         // Bits per character
	localparam int unsigned CHAR_CYC_DEF  =
		(CLK_HZ * CHAR_BITS + BAUD_DEFAULT - 1) / BAUD_DEFAULT;
	// Frame silence is 3.5 character times, kept as 7/2
	localparam int unsigned SIL_NUM       = 7;
	localparam int unsigned SIL_DEN       = 2;
	// Measurement period
	localparam int unsigned MEAS_PERIOD_MS = 2000;
	localparam int unsigned MEAS_CYC_DEF   = CLK_HZ / 1000 * MEAS_PERIOD_MS;
	// Master response timeout, in character times
	localparam int unsigned RESP_TMO_CHARS = 100;
	// Frame content
	localparam logic [7:0]  DEV_ADDR_DEF  = 8'hF0;   // Default slave address
	localparam logic [7:0]  FUNC_WR_MULTI = 8'h10;   // Write multiple regs
	localparam logic [15:0] CRC_INIT      = 16'hFFFF;
	localparam logic [15:0] CRC_POLY      = 16'hA001;
	localparam logic [7:0]  CRC_LEN       = 8'h02;
	// Byte positions inside request and response
	localparam logic [3:0]  IX_ADDR       = 4'h0;
	localparam logic [3:0]  IX_FUNC       = 4'h1;
	localparam logic [3:0]  IX_START_HI   = 4'h2;
	localparam logic [3:0]  IX_START_LO   = 4'h3;
	localparam logic [3:0]  IX_COUNT_HI   = 4'h4;
	localparam logic [3:0]  IX_COUNT_LO   = 4'h5;
	localparam logic [3:0]  IX_BYTES      = 4'h6;
	localparam logic [3:0]  IX_RESP_CRC   = 4'h6;
	localparam logic [3:0]  IX_RESP_LAST  = 4'h7;
	localparam logic [7:0]  RQ_DATA       = 8'h07;   // First data byte
	localparam logic [3:0]  RESP_LEN      = 4'h8;
	// Wire addresses of the device registers (number minus one)
	localparam logic [15:0] REG_PRESS_LO  = 16'h0208;
	localparam logic [15:0] REG_PRESS_HI  = 16'h0209;
	localparam logic [15:0] REG_FACTOR    = 16'h0308;
	localparam logic [15:0] FACTOR_MAX    = 16'h0064;
	localparam logic [15:0] FACTOR_RESET  = 16'h0064;
	localparam int unsigned FACTOR_SCALE  = 100;
	// Master register map on AHB-Lite (byte offsets)
	localparam logic [7:0]  A_CTRL        = 8'h00;
	localparam logic [7:0]  A_STATUS      = 8'h04;
	localparam logic [7:0]  A_SLAVE       = 8'h08;
	localparam logic [7:0]  A_START       = 8'h0C;
	localparam logic [7:0]  A_COUNT       = 8'h10;
	localparam logic [7:0]  A_DATA0       = 8'h14;
	localparam logic [7:0]  A_DATA1       = 8'h18;
	localparam int unsigned ST_BUSY       = 0;
	localparam int unsigned ST_DONE       = 1;
	localparam int unsigned ST_ACK_OK     = 2;
	localparam int unsigned ST_ACK_BAD    = 3;
	// State encodings, Gray along the usual path
	typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} mbf_tx_type;
	typedef enum logic [1:0] {
		M_IDLE = 2'b00, M_GAP = 2'b01, M_SEND = 2'b11, M_RESP = 2'b10
	} mbf_mst_type;

	// One byte of the CRC, reflected polynomial, LSB first
	function automatic logic [15:0] mbf_crc_step(input logic [15:0] crc,
		input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction : mbf_crc_step

	// Header bytes common to request and response
	function automatic logic [7:0] mbf_hdr_byte(input logic [3:0] ix,
		input logic [7:0] addr, input logic [15:0] start,
		input logic [15:0] count);
		logic [7:0] b;
		b = 8'h00;
		case (ix)
			IX_ADDR:     b = addr;
			IX_FUNC:     b = FUNC_WR_MULTI;
			IX_START_HI: b = start[15:8];
			IX_START_LO: b = start[7:0];
			IX_COUNT_HI: b = count[15:8];
			IX_COUNT_LO: b = count[7:0];
			default:     b = 8'h00;
		endcase
		return b;
	endfunction : mbf_hdr_byte
endpackage : mbf_pkg
`default_nettype wire

// File: tb/mbf_link_asserts.sv
// Link checker: character timing and reply framing on both strobes.
// Assumes 8-cycle characters and a 28-cycle frame silence.
`default_nettype none
module mbf_link_asserts
	import mbf_pkg::*;
(
	// Clock and reset
	input wire logic       hclk,
	input wire logic       hresetn,
	// Link strobes
	input wire logic       m2s_valid,
	input wire logic [7:0] m2s_data,
	input wire logic       s2m_valid,
	input wire logic [7:0] s2m_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] quiet; // Cycles since last strobe, saturating
	// Quiet time over both directions
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			quiet <= 6'h3F;
		else if (m2s_valid || s2m_valid)
			quiet <= 6'h00;
		else if (quiet != 6'h3F)
			quiet <= quiet + 6'h01;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence rsp_start;
		s2m_valid && quiet >= 6'h1C;
	endsequence
	sequence req_start;
		m2s_valid && quiet >= 6'h1C;
	endsequence
	chk_req_gap: assert property (m2s_valid |-> quiet == 6'h07 ||
		quiet >= 6'h1C) else $error("request gap");
	chk_rsp_gap: assert property (s2m_valid |-> quiet == 6'h07 ||
		quiet >= 6'h1C) else $error("reply gap");
	chk_one_talker: assert property (!(m2s_valid && s2m_valid))
		else $error("both ends talk");
	chk_req_space: assert property (m2s_valid |=> !m2s_valid [*7])
		else $error("request spacing");
	chk_rsp_space: assert property (s2m_valid |=> !s2m_valid [*7])
		else $error("reply spacing");
	chk_req_func: assert property (req_start |-> ##8 (m2s_valid &&
		m2s_data == FUNC_WR_MULTI)) else $error("request function");
	chk_rsp_addr: assert property (rsp_start |->
		s2m_data == DEV_ADDR_DEF) else $error("reply address");
	chk_rsp_func: assert property (rsp_start |-> ##8 (s2m_valid &&
		s2m_data == FUNC_WR_MULTI)) else $error("reply function");
	chk_rsp_len: assert property (rsp_start |-> ##56 s2m_valid
		##8 !s2m_valid) else $error("reply length");
endmodule : mbf_link_asserts
`default_nettype wire

// File: tb/tb.sv
// Bench: master and device joined by one link, orders over AHB-Lite.
// Assumes short counts: 8-cycle characters, samples every 400 cycles.
`default_nettype none
`define CK(n, e, s) n_tests++; if ((s) !== (e)) begin n_mismatch++; \
	$display("BAD %s exp %h got %h", n, e, s); end
module tb
	import mbf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        hclk, hresetn, hsel, hwrite, hrdy, hresp, take;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, press;
	logic [15:0] meas, filt, fac;
	logic [7:0]  mq[$], sq[$]; // Characters seen on each direction
	int          n_mismatch, n_tests;
	logic        f_ok, f_bad; // Frame verdict pulses
	logic [31:0] rd;          // Read-back word
	int          n_ok, n_bad; // Frames accepted and rejected
	localparam logic [7:0] REQ[13] = '{8'hF0, 8'h10, 8'h02, 8'h08,
		8'h00, 8'h02, 8'h04, 8'h50, 8'h00, 8'h44, 8'h7D, 8'h0E, 8'hB7};
	localparam logic [7:0] RSP[8] = '{8'hF0, 8'h10, 8'h02, 8'h08,
		8'h00, 8'h02, 8'hD4, 8'h93};
	mbf_link_if lk ();
	mbf_master #(.CHAR_CYCLES(8), .TMO_CYCLES(2000)) mbf_master_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
		.link(lk.master));
	mbf_device #(.CHAR_CYCLES(8), .MEAS_CYCLES(400)) mbf_device_i (
		.hclk(hclk), .hresetn(hresetn), .link(lk.device),
		.meas_value(meas), .sample_take(take), .filt_out(filt),
		.comp_pressure(press), .filter_factor(fac), .frame_ok(f_ok),
		.frame_bad(f_bad));
	mbf_link_asserts mbf_link_asserts_i (.hclk(hclk), .hresetn(hresetn),
		.m2s_valid(lk.m2s_valid), .m2s_data(lk.m2s_data),
		.s2m_valid(lk.s2m_valid), .s2m_data(lk.s2m_data));
	always #20 hclk = ~hclk;
	// Record every character on the wire
	always @(posedge hclk) begin
		if (lk.m2s_valid === 1'b1)
			mq.push_back(lk.m2s_data);
		if (lk.s2m_valid === 1'b1)
			sq.push_back(lk.s2m_data);
		if (f_ok === 1'b1)
			n_ok++;
		if (f_bad === 1'b1)
			n_bad++;
	end
	task automatic stop_test;
		if (n_mismatch == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	// Wait for hready under a bound
	task automatic rdy;
		for (int k = 0; k < 50; k++) begin
			@(posedge hclk);
			if (hrdy === 1'b1)
				return;
		end
		n_mismatch++;
		stop_test();
	endtask : rdy
	// One single AHB-Lite word transfer
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		rdy();
		r = hrdata;
	endtask : ahb
	// Order one write frame and judge the final status
	task automatic send(input logic [7:0] sl, input logic [15:0] st,
		input logic [31:0] n, input logic [15:0] d0, d1,
		input logic [31:0] e);
		logic [31:0] r;
		ahb(1'b1, A_SLAVE, {24'h00_0000, sl}, r);
		ahb(1'b1, A_START, {16'h0000, st}, r);
		ahb(1'b1, A_COUNT, n, r);
		ahb(1'b1, A_DATA0, {16'h0000, d0}, r);
		ahb(1'b1, A_DATA1, {16'h0000, d1}, r);
		mq = {};
		sq = {};
		ahb(1'b1, A_CTRL, 32'h1, r);
		r = 32'h0;
		for (int k = 0; k < 3000 && r[ST_DONE] !== 1'b1; k++)
			ahb(1'b0, A_STATUS, 32'h0, r);
		`CK("status", e, r)
		if (r[ST_DONE] !== 1'b1)
			stop_test();
	endtask : send
	// Present a measurement and check the output after its sample
	task automatic samp(input logic [15:0] m, input logic [15:0] e);
		meas <= m;
		// Skip any sample taken before the new value stood
		repeat (2) @(posedge hclk);
		for (int k = 0; k < 1000 && take !== 1'b1; k++)
			@(posedge hclk);
		`CK("filt", e, filt)
		if (take !== 1'b1) begin
			n_mismatch++;
			stop_test();
		end
		@(posedge hclk);
	endtask : samp
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata, meas} = '0;
		hsize = 3'b010;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		`CK("factor", 16'h0064, fac)
		samp(16'h03E8, 16'h03E8);
		samp(16'h07D0, 16'h07D0);
		send(DEV_ADDR_DEF, REG_FACTOR, 1, 16'h0032, 0, 32'h6);
		`CK("factor", 16'h0032, fac)
		samp(16'h0BB8, 16'h09C4);
		samp(16'h0BB8, 16'h0ABE);
		send(DEV_ADDR_DEF, REG_FACTOR, 1, 16'h0065, 0, 32'h6);
		`CK("factor", 16'h0032, fac)
		send(DEV_ADDR_DEF, REG_PRESS_LO, 2, 16'h5000, 16'h447D, 32'h6);
		`CK("press", 32'h447D_5000, press)
		ahb(1'b0, A_DATA1, 32'h0, rd);
		`CK("data1", 32'h0000_447D, rd)
		ahb(1'b0, A_START, 32'h0, rd);
		`CK("start", 32'h0000_0208, rd)
		for (int i = 0; i < 13; i++) begin
			`CK("req", REQ[i], mq[i])
		end
		for (int i = 0; i < 8; i++) begin
			`CK("rsp", RSP[i], sq[i])
		end
		send(8'h01, REG_PRESS_LO, 2, 16'h0000, 16'h0000, 32'hA);
		`CK("press", 32'h447D_5000, press)
		`CK("oks", 3, n_ok)
		`CK("bads", 1, n_bad)
		`CK("hresp", 1'b0, hresp)
		stop_test();
	end
endmodule : tb
`default_nettype wire
